// ---- inc/ucer_pkg.sv ----
// package of offsets, field positions and reset values for the uncorrectable error block
package ucer_pkg;

    // configuration space byte offsets of the registers
    localparam logic [11:0] UCER_HDR_OFS = 12'h100;
    localparam logic [11:0] UCER_STS_OFS = 12'h104;
    localparam logic [11:0] UCER_MSK_OFS = 12'h108;
    localparam logic [11:0] UCER_SEV_OFS = 12'h10C;
    localparam int unsigned UCER_CFG_ADDR_W = 12;
    localparam int unsigned UCER_DW_LSB = 2;

    // capability header fields
    localparam logic [11:0] UCER_NEXT_CAP_PTR = 12'h140;
    localparam logic [3:0] UCER_CAP_VERSION = 4'h1;
    localparam logic [15:0] UCER_EXT_CAP_ID = 16'h0001;
    localparam logic [31:0] UCER_HDR_VALUE = {UCER_NEXT_CAP_PTR, UCER_CAP_VERSION,
                                              UCER_EXT_CAP_ID};

    // error bit positions, shared by status, mask and severity
    localparam int unsigned UCER_BIT_TRAIN = 0;
    localparam int unsigned UCER_BIT_DLP = 4;
    localparam int unsigned UCER_BIT_SLD = 5;
    localparam int unsigned UCER_BIT_POISON = 12;
    localparam int unsigned UCER_BIT_FCP = 13;
    localparam int unsigned UCER_BIT_CTO = 14;
    localparam int unsigned UCER_BIT_CA = 15;
    localparam int unsigned UCER_BIT_UC = 16;
    localparam int unsigned UCER_BIT_RXOVF = 17;
    localparam int unsigned UCER_BIT_MALF = 18;
    localparam int unsigned UCER_BIT_UR = 20;
    localparam int unsigned UCER_BIT_HLRTO = 21;

    // implemented bits of a downstream root port and of the hub-link port
    localparam logic [31:0] UCER_IMPL_ROOT = 32'h0017_F031;
    localparam logic [31:0] UCER_IMPL_HUB = 32'h0037_F031;

    // severity reset values (1 = fatal)
    localparam logic [31:0] UCER_SEV_RST_ROOT = 32'h0006_2011;
    localparam logic [31:0] UCER_SEV_RST_HUB = 32'h0026_2011;

    // status and mask reset value
    localparam logic [31:0] UCER_STS_RST = 32'h0000_0000;
    localparam logic [31:0] UCER_MSK_RST = 32'h0000_0000;

    // status bits that are plain read-write instead of write-one-to-clear
    localparam logic [31:0] UCER_STS_RW_BITS = 32'h0000_0020;

    localparam logic [31:0] UCER_ZERO_WORD = 32'h0000_0000;

endpackage

// ---- testbench/tb_top.sv ----
// self-checking bench of the uncorrectable error block, hub-link build
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module tb_top;
    import ucer_pkg::*;
    logic core_clk, resetn, warm_resetn, cfg_rd, cfg_wr, rvalid, fat, nf, fat_p, nf_p;
    logic [11:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, det, dmask, rdata, q, sts, msk, sev, d;
    logic [31:0] rdata_root;
    int seed, i, checks, error_cnt;
    ucer_det_model ptn_u (.core_clk_i(core_clk), .err_detect_o(det));
    ucer_error_regs #(.HUB_LINK_PORT(1)) dut_u (.core_clk_i(core_clk), .resetn_i(resetn),
        .warm_resetn_i(warm_resetn), .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr),
        .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
        .err_detect_i(det), .uncorrectable_detect_mask_i(dmask), .cfg_rdata_o(rdata),
        .cfg_rd_valid_o(rvalid), .fatal_err_o(fat), .nonfatal_err_o(nf),
        .fatal_pending_o(fat_p), .nonfatal_pending_o(nf_p));
    // root port build on the same bus; only its read data is watched
    ucer_error_regs #(.HUB_LINK_PORT(0)) dut_root_u (.core_clk_i(core_clk), .resetn_i(resetn),
        .warm_resetn_i(warm_resetn), .cfg_rd_i(cfg_rd), .cfg_wr_i(cfg_wr),
        .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
        .err_detect_i(det), .uncorrectable_detect_mask_i(dmask), .cfg_rdata_o(rdata_root),
        .cfg_rd_valid_o(), .fatal_err_o(), .nonfatal_err_o(),
        .fatal_pending_o(), .nonfatal_pending_o());
    task automatic cfg(input logic w, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] be);
        @(negedge core_clk);
        cfg_rd = !w;
        cfg_wr = w;
        cfg_addr = a;
        cfg_wdata = wd;
        cfg_be = be;
        @(negedge core_clk);
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        q = rdata;
        if (!w) `CHK("rd_valid", 1'b1, rvalid)
    endtask
    function automatic logic [31:0] rec(input logic [31:0] x, input logic [31:0] m);
        return x & UCER_IMPL_HUB & ~m;
    endfunction
    task automatic hit(input logic [31:0] x, input int dly);
        logic [31:0] r;
        r = rec(x, dmask);
        ptn_u.fire(x, dly);
        `CHK("fatal_pulse", |(r & ~msk & sev), fat)
        `CHK("nonfatal_pulse", |(r & ~msk & ~sev), nf)
        sts = sts | r;
    endtask
    task automatic wsts(input logic [31:0] x);
        cfg(1'b1, UCER_STS_OFS, x, 4'hF);
        sts = (sts & ~x & ~UCER_STS_RW_BITS) | (x & UCER_STS_RW_BITS);
    endtask
    task automatic chk_regs;
        cfg(1'b0, UCER_STS_OFS, 0, 4'hF);
        `CHK("status", sts, q)
        `CHK("root_sts_21", 1'b0, rdata_root[21])
        cfg(1'b0, UCER_MSK_OFS, 0, 4'hF);
        `CHK("mask", msk, q)
        cfg(1'b0, UCER_SEV_OFS, 0, 4'hF);
        `CHK("severity", sev, q)
        `CHK("fatal_level", |(sts & ~msk & sev), fat_p)
        `CHK("nonfatal_level", |(sts & ~msk & ~sev), nf_p)
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (6000) @(posedge core_clk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        seed = 32'hc1c1;
        {resetn, cfg_rd, cfg_wr, cfg_addr, cfg_wdata, dmask} = '0;
        warm_resetn = 1'b1;
        cfg_be = 4'hF;
        sts = 32'h0000_0000;
        msk = 32'h0000_0000;
        sev = UCER_SEV_RST_HUB;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) resetn = 1'b1;
        cfg(1'b1, UCER_HDR_OFS, 32'hFFFF_FFFF, 4'hF);
        cfg(1'b0, UCER_HDR_OFS, 0, 4'hF);
        `CHK("header", 32'h1401_0001, q)
        cfg(1'b0, 12'h110, 0, 4'hF);
        `CHK("unmapped", 32'h0000_0000, q)
        chk_regs;
        `CHK("root_severity", UCER_SEV_RST_ROOT, rdata_root)
        // bit 0 is left out: its behaviour is not to be relied on
        for (i = 1; i < 22; i++) if (UCER_IMPL_HUB[i]) begin
            hit(32'h1 << i, i % 3);
            chk_regs;
            wsts(32'h1 << i);
        end
        cfg(1'b1, UCER_MSK_OFS, 32'hFFFF_FFFF, 4'hF);
        msk = UCER_IMPL_HUB;
        hit(32'h0000_2000, 0);
        chk_regs;
        cfg(1'b1, UCER_MSK_OFS, 32'h0000_0000, 4'h1);
        msk = msk & 32'hFFFF_FF00;
        chk_regs;
        wsts(32'hFFFF_FFFF);
        cfg(1'b1, UCER_SEV_OFS, 32'hFFFF_FFFF, 4'hF);
        sev = UCER_IMPL_HUB;
        hit(32'h0002_0000, 1);
        @(negedge core_clk) warm_resetn = 1'b0;
        // an error and a read inside warm reset: status records, no pulse, no answer
        ptn_u.fire(32'h0000_0010, 0);
        sts = sts | 32'h0000_0010;
        `CHK("warm_pulse", 1'b0, fat)
        cfg_rd = 1'b1;
        @(negedge core_clk) cfg_rd = 1'b0;
        `CHK("warm_rd_valid", 1'b0, rvalid)
        repeat (3) @(negedge core_clk);
        warm_resetn = 1'b1;
        chk_regs;
        repeat (40) begin
            dmask = $random(seed) & $random(seed);
            hit($random(seed) & 32'hFFFF_FFFE, 0);
            d = $random(seed);
            cfg(1'b1, UCER_SEV_OFS, d, 4'hF);
            sev = d & UCER_IMPL_HUB;
            d = $random(seed);
            cfg(1'b1, UCER_MSK_OFS, d, 4'hF);
            msk = d & UCER_IMPL_HUB;
            chk_regs;
            wsts($random(seed));
        end
        chk_regs;
        // a power-on reset mid-run must bring every sticky bit back to its default
        @(negedge core_clk) resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        sts = UCER_STS_RST;
        msk = UCER_MSK_RST;
        sev = UCER_SEV_RST_HUB;
        chk_regs;
        `CHK("root_sev_por", UCER_SEV_RST_ROOT, rdata_root)
        tally_and_finish();
    end
endmodule

// ---- testbench/ucer_chk_sva.sv ----
// port assertions of the uncorrectable error block
`timescale 1ns/10ps
module ucer_chk
import ucer_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic warm_resetn_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [ucer_pkg::UCER_CFG_ADDR_W-1:0] cfg_addr_i,
    input wire logic [31:0] err_detect_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic cfg_rd_valid_o,
    input wire logic fatal_err_o,
    input wire logic nonfatal_err_o,
    input wire logic fatal_pending_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_rd; cfg_rd_i && warm_resetn_i; endsequence
    sequence s_fat; !cfg_wr_i ##1 fatal_err_o; endsequence
    sequence s_still; !warm_resetn_i && !cfg_wr_i && !(|err_detect_i); endsequence
    property p_rd_valid; s_rd |=> cfg_rd_valid_o; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_no_spur; cfg_rd_valid_o |-> $past(cfg_rd_i); endproperty
    a_no_spur: assert property (p_no_spur) else $error("answer without read");
    property p_hdr;
        s_rd ##0 (cfg_addr_i[11:2] == UCER_HDR_OFS[11:2]) |=> cfg_rdata_o == UCER_HDR_VALUE;
    endproperty
    a_hdr: assert property (p_hdr) else $error("header value wrong");
    property p_fat_cause; fatal_err_o |-> $past(|err_detect_i); endproperty
    a_fat_cause: assert property (p_fat_cause) else $error("fatal without cause");
    property p_nf_cause; nonfatal_err_o |-> $past(|err_detect_i); endproperty
    a_nf_cause: assert property (p_nf_cause) else $error("nonfatal without cause");
    property p_pend; s_fat |=> fatal_pending_o; endproperty
    a_pend: assert property (p_pend) else $error("fatal level missing");
    property p_warm_clr; !warm_resetn_i |=> !cfg_rd_valid_o && !fatal_err_o && !nonfatal_err_o;
    endproperty
    a_warm_clr: assert property (p_warm_clr) else $error("warm reset left pulse");
    property p_warm_keep; s_still [*2] |=> $stable(fatal_pending_o); endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("warm reset lost level");
endmodule
bind ucer_error_regs ucer_chk chk_u (.core_clk_i, .resetn_i, .warm_resetn_i, .cfg_rd_i,
    .cfg_wr_i, .cfg_addr_i, .err_detect_i, .cfg_rdata_o, .cfg_rd_valid_o, .fatal_err_o,
    .nonfatal_err_o, .fatal_pending_o);

// ---- testbench/ucer_det_model.sv ----
// behavioural model of the link and transaction layer error detectors
`timescale 1ns/10ps
module ucer_det_model (
    input wire logic core_clk_i,
    output logic [31:0] err_detect_o
);
    initial err_detect_o = 32'h0000_0000;
    // one pulse per event; a delay models a detector that reports late
    task automatic fire(input logic [31:0] pat, input int dly);
        repeat (dly) @(negedge core_clk_i);
        @(negedge core_clk_i);
        err_detect_o = pat;
        @(negedge core_clk_i);
        err_detect_o = 32'h0000_0000;
    endtask
endmodule

// ---- verilog/ucer_cfg_decode.sv ----
// address decode of the four configuration dwords of the block
`timescale 1ns/10ps
module ucer_cfg_decode (
    input wire logic [ucer_pkg::UCER_CFG_ADDR_W-1:0] addr_i,
    output logic sel_hdr_o,
    output logic sel_sts_o,
    output logic sel_msk_o,
    output logic sel_sev_o
);
    import ucer_pkg::*;

    logic [UCER_CFG_ADDR_W-1:UCER_DW_LSB] dw;

    // byte lanes are given by enables, so the low address bits are ignored
    assign dw = addr_i[UCER_CFG_ADDR_W-1:UCER_DW_LSB];
    assign sel_hdr_o = (dw == UCER_HDR_OFS[UCER_CFG_ADDR_W-1:UCER_DW_LSB]);
    assign sel_sts_o = (dw == UCER_STS_OFS[UCER_CFG_ADDR_W-1:UCER_DW_LSB]);
    assign sel_msk_o = (dw == UCER_MSK_OFS[UCER_CFG_ADDR_W-1:UCER_DW_LSB]);
    assign sel_sev_o = (dw == UCER_SEV_OFS[UCER_CFG_ADDR_W-1:UCER_DW_LSB]);

endmodule

// ---- verilog/ucer_error_regs.sv ----
// uncorrectable error capability of one root port or of the hub-link port
//
// Function
// - header bits 31:20 read the fixed next pointer 140h
// - header bits 19:16 read version 1h, writes ignored
// - header bits 15:0 read identifier 0001h, read-only
// - a detected error not masked at detection sets its status bit
// - status bits 20,18,17,16,15,14,13,12,5,4,0 by error type; others reserved
// - hub-link port adds status bit 21 for link reset timeout
// - status sticky write-one-clear; bit 5 sticky read-write; all reset 0
// - set mask bit stops the error being signalled; sticky, resets 0
// - mask bits sit at status positions, bit 21 on hub-link port
// - severity bit 1 classifies error fatal, 0 non-fatal
// - status with severity picks fatal or non-fatal log reporting
// - hub-link severity 21,18,17,13,4,0 reset 1, others 0, sticky
// - root port severity 18,17,13 reset 1; 20,16,15,14,12 reset 0
// - root port severity 5 resets 0; bits 4 and 0 reset 1
`timescale 1ns/10ps
module ucer_error_regs #(
    parameter int unsigned HUB_LINK_PORT = 0
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic warm_resetn_i,
    input wire logic cfg_rd_i,
    input wire logic cfg_wr_i,
    input wire logic [ucer_pkg::UCER_CFG_ADDR_W-1:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic [31:0] err_detect_i,
    input wire logic [31:0] uncorrectable_detect_mask_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rd_valid_o,
    output logic fatal_err_o,
    output logic nonfatal_err_o,
    output logic fatal_pending_o,
    output logic nonfatal_pending_o
);
    import ucer_pkg::*;

    localparam logic [31:0] IMPL = (HUB_LINK_PORT != 0) ? UCER_IMPL_HUB : UCER_IMPL_ROOT;
    localparam logic [31:0] SEV_RST = (HUB_LINK_PORT != 0) ? UCER_SEV_RST_HUB
                                                          : UCER_SEV_RST_ROOT;

    generate
        if (HUB_LINK_PORT > 1) begin : g_bad_param
            $error("HUB_LINK_PORT must be 0 or 1");
        end
    endgenerate

    // decode of the access
    logic sel_hdr;
    logic sel_sts;
    logic sel_msk;
    logic sel_sev;

    ucer_cfg_decode u_decode (
        .addr_i(cfg_addr_i),
        .sel_hdr_o(sel_hdr),
        .sel_sts_o(sel_sts),
        .sel_msk_o(sel_msk),
        .sel_sev_o(sel_sev)
    );

    // per-bit write enable from the byte enables
    logic [31:0] lane_en;
    logic [31:0] wr_sts;
    logic [31:0] wr_msk;
    logic [31:0] wr_sev;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            lane_en[b*8 +: 8] = {8{cfg_be_i[b]}};
        end
    end

    // header has no write path at all, so a write there just falls away
    assign wr_sts = {32{cfg_wr_i & sel_sts}} & lane_en;
    assign wr_msk = {32{cfg_wr_i & sel_msk}} & lane_en;
    assign wr_sev = {32{cfg_wr_i & sel_sev}} & lane_en;

    // errors that pass the detection mask
    logic [31:0] err_event;

    assign err_event = err_detect_i & ~uncorrectable_detect_mask_i & IMPL;

    // status, mask and severity storage
    logic [31:0] sts_q;
    logic [31:0] msk_q;
    logic [31:0] sev_q;

    // implemented bits and severity reset values follow the port kind; status and mask resets and bit classes are the same for both
    generate
        for (genvar i = 0; i < 32; i++) begin : g_bit
            if (IMPL[i]) begin : g_impl
                ucer_sticky_bit #(
                    .RST_VAL(UCER_STS_RST[i]),
                    .W1C(!UCER_STS_RW_BITS[i])
                ) u_sts (
                    .core_clk_i(core_clk_i),
                    .resetn_i(resetn_i),
                    .set_i(err_event[i]),
                    .wr_i(wr_sts[i]),
                    .wdata_i(cfg_wdata_i[i]),
                    .q_o(sts_q[i])
                );
                ucer_sticky_bit #(
                    .RST_VAL(UCER_MSK_RST[i]),
                    .W1C(1'b0)
                ) u_msk (
                    .core_clk_i(core_clk_i),
                    .resetn_i(resetn_i),
                    .set_i(1'b0),
                    .wr_i(wr_msk[i]),
                    .wdata_i(cfg_wdata_i[i]),
                    .q_o(msk_q[i])
                );
                ucer_sticky_bit #(
                    .RST_VAL(SEV_RST[i]),
                    .W1C(1'b0)
                ) u_sev (
                    .core_clk_i(core_clk_i),
                    .resetn_i(resetn_i),
                    .set_i(1'b0),
                    .wr_i(wr_sev[i]),
                    .wdata_i(cfg_wdata_i[i]),
                    .q_o(sev_q[i])
                );
            end else begin : g_rsvd
                // reserved positions read as zero
                assign sts_q[i] = 1'b0;
                assign msk_q[i] = 1'b0;
                assign sev_q[i] = 1'b0;
            end
        end
    endgenerate

    // the training error bit at position 0 behaves like the others here, but
    // software is told not to trust it, so no special case is built for it

    // new errors allowed through the signalling mask, split by severity
    logic [31:0] err_signal;
    logic fatal_now;
    logic nonfatal_now;

    assign err_signal = err_event & ~msk_q;
    assign fatal_now = |(err_signal & sev_q);
    assign nonfatal_now = |(err_signal & ~sev_q);

    // recorded errors still waiting for software, by class
    logic fatal_pend_nxt;
    logic nonfatal_pend_nxt;

    assign fatal_pend_nxt = |(sts_q & ~msk_q & sev_q);
    assign nonfatal_pend_nxt = |(sts_q & ~msk_q & ~sev_q);

    // one-cycle report pulses toward the device first/next error logs;
    // these are not sticky, so a warm reset drops a report in flight
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fatal_err_o <= 1'b0;
            nonfatal_err_o <= 1'b0;
        end else if (!warm_resetn_i) begin
            fatal_err_o <= 1'b0;
            nonfatal_err_o <= 1'b0;
        end else begin
            fatal_err_o <= fatal_now;
            nonfatal_err_o <= nonfatal_now;
        end
    end

    // pending levels follow the sticky state, one cycle behind it
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fatal_pending_o <= 1'b0;
            nonfatal_pending_o <= 1'b0;
        end else begin
            fatal_pending_o <= fatal_pend_nxt;
            nonfatal_pending_o <= nonfatal_pend_nxt;
        end
    end

    // read data mux; unmapped dwords read as zero
    logic [31:0] rdata_nxt;

    always_comb begin
        rdata_nxt = UCER_ZERO_WORD;
        if (sel_hdr) begin
            rdata_nxt = UCER_HDR_VALUE;
        end else if (sel_sts) begin
            rdata_nxt = sts_q;
        end else if (sel_msk) begin
            rdata_nxt = msk_q;
        end else if (sel_sev) begin
            rdata_nxt = sev_q;
        end
    end

    // read answer one cycle after the request; it shows the state before any
    // write or error taken in that same cycle
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_rdata_o <= UCER_ZERO_WORD;
            cfg_rd_valid_o <= 1'b0;
        end else if (!warm_resetn_i) begin
            cfg_rdata_o <= UCER_ZERO_WORD;
            cfg_rd_valid_o <= 1'b0;
        end else begin
            cfg_rd_valid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= rdata_nxt;
            end
        end
    end

endmodule

// ---- verilog/ucer_sticky_bit.sv ----
// one sticky configuration bit, either write-one-to-clear or read-write
`timescale 1ns/10ps
module ucer_sticky_bit #(
    parameter bit RST_VAL = 1'b0,
    parameter bit W1C = 1'b0
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic q_o
);

    // only the power-on reset reaches this flop, so the value survives warm resets
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q_o <= RST_VAL;
        end else if (set_i) begin
            // a new error beats a clear in the same cycle
            q_o <= 1'b1;
        end else if (wr_i) begin
            if (W1C) begin
                q_o <= q_o & ~wdata_i;
            end else begin
                q_o <= wdata_i;
            end
        end
    end

endmodule
